// ### src/trac_pkg.sv
`default_nettype none
package trac_pkg;
    // control byte layout
    localparam int unsigned CTL_REG_COMM_BIT = 7;
    localparam int unsigned CTL_WRITE_BIT = 6;
    localparam int unsigned CTL_ADDR_MSB = 5;
    localparam int unsigned CTL_ADDR_LSB = 0;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 16;
    // register map
    localparam logic [5:0] WRITE_UNLOCK_CODE_OFS = 6'h1F;
    // code word values
    localparam logic [15:0] UNLOCK_CODE = 16'h1235;
    localparam logic [15:0] WRITE_UNLOCK_CODE_RST = 16'h0000;
    localparam logic [7:0] WRITE_ACK_MASK = 8'hBF;
    localparam logic [15:0] WRITE_IN_WORD = 16'h0000;
    // sequencer states
    typedef enum logic [2:0] {
        TRAC_IDLE = 3'b001,
        TRAC_ACCESS = 3'b010,
        TRAC_ANSWER = 3'b100
    } trac_state_t;
endpackage
`default_nettype wire

// ### src/trac_mem_if.sv
`default_nettype none
interface trac_mem_if;
    logic we;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### src/trac_regmem.sv
`default_nettype none
module trac_regmem #(
    parameter int unsigned DEPTH = 64 // number of register words
) (
    input wire logic clk, // process-data clock
    trac_mem_if.mem port // access port
);
    logic [15:0] mem [DEPTH];

    // synchronous write, registered read of old contents
    always_ff @(posedge clk) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        port.rdata <= mem[port.addr];
    end
endmodule
`default_nettype wire

// ### src/trac_channel.sv
`default_nettype none
// Notes on behaviour
// - Control bit 7 set selects register communication; only then is a register accessed.
// - Control bit 6 set during register communication writes the output word to the register.
// - Control bits 5..0 give the register number, 0 to 63.
// - After a read the status byte echoes the control byte unchanged.
// - A read returns the addressed register's present contents in the input word.
// - After a write the status byte equals the control byte with bit 6 cleared.
// - Writing zero to the code-word register 31 re-enables write protection.
// - The data word travels high byte first, then low byte.
// - Bit 6 clear means a read, and the output word is ignored.
// - While protected, writes to every register but 31 are rejected.
// - Writing 0x1235 to register 31 lifts protection; any other value restores it.
module trac_channel (
    input wire logic MCLK, // 10 MHz clock
    input wire logic RSTN, // synchronous reset, active low
    input wire logic PD_STROBE, // one-cycle pulse: new output data valid
    input wire logic [7:0] CTRL_BYTE, // control byte (byte 0)
    input wire logic [7:0] HOST_OUT_HI, // host_out_word high byte (byte 1)
    input wire logic [7:0] HOST_OUT_LO, // host_out_word low byte (byte 2)
    input wire logic [7:0] MEAS_STATUS, // normal-mode status byte
    input wire logic [15:0] MEAS_WORD, // normal-mode process value
    output logic [7:0] STATUS_BYTE, // status byte (byte 0)
    output logic [7:0] TERMINAL_IN_HI, // terminal_in_word high byte (byte 1)
    output logic [7:0] TERMINAL_IN_LO, // terminal_in_word low byte (byte 2)
    output logic ANSWER_VALID, // one-cycle pulse: answer updated
    output logic WRITE_UNLOCKED // write protection lifted
);
    typedef struct packed {
        trac_pkg::trac_state_t state;
        logic [7:0] ctrl;
        logic [15:0] wdata;
        logic [7:0] status;
        logic [15:0] in_word;
        logic ack;
        logic unlocked;
        logic [15:0] code;
    } trac_regs_t;

    trac_regs_t r_reg;
    trac_regs_t r_next;
    trac_mem_if mem_bus ();

    logic [5:0] addr;
    logic is_write;
    logic is_code_reg;
    logic write_ok;

    trac_regmem #(
        .DEPTH(64)
    ) u_regmem (
        .clk(MCLK),
        .port(mem_bus.mem)
    );

    // decode of the latched control byte
    assign addr = r_reg.ctrl[trac_pkg::CTL_ADDR_MSB:trac_pkg::CTL_ADDR_LSB];
    assign is_write = r_reg.ctrl[trac_pkg::CTL_WRITE_BIT];
    assign is_code_reg = (addr == trac_pkg::WRITE_UNLOCK_CODE_OFS);
    assign write_ok = is_code_reg || r_reg.unlocked;

    // memory port: written only in the access cycle of a permitted write
    assign mem_bus.we = (r_reg.state == trac_pkg::TRAC_ACCESS) && is_write && write_ok;
    assign mem_bus.addr = addr;
    assign mem_bus.wdata = r_reg.wdata;

    // sequencer and answer build-up
    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        unique case (r_reg.state)
            trac_pkg::TRAC_IDLE: begin
                if (PD_STROBE) begin
                    if (CTRL_BYTE[trac_pkg::CTL_REG_COMM_BIT]) begin
                        r_next.ctrl = CTRL_BYTE;
                        r_next.wdata = {HOST_OUT_HI, HOST_OUT_LO};
                        r_next.state = trac_pkg::TRAC_ACCESS;
                    end else begin
                        r_next.status = MEAS_STATUS;
                        r_next.in_word = MEAS_WORD;
                        r_next.ack = 1'b1;
                    end
                end
            end
            trac_pkg::TRAC_ACCESS: begin
                if (is_write && is_code_reg) begin
                    r_next.code = r_reg.wdata;
                    r_next.unlocked = (r_reg.wdata == trac_pkg::UNLOCK_CODE);
                end
                r_next.state = trac_pkg::TRAC_ANSWER;
            end
            trac_pkg::TRAC_ANSWER: begin
                if (is_write) begin
                    r_next.status = r_reg.ctrl & trac_pkg::WRITE_ACK_MASK;
                    r_next.in_word = trac_pkg::WRITE_IN_WORD;
                end else begin
                    r_next.status = r_reg.ctrl;
                    r_next.in_word = is_code_reg ? r_reg.code : mem_bus.rdata;
                end
                r_next.ack = 1'b1;
                r_next.state = trac_pkg::TRAC_IDLE;
            end
            default: begin
                r_next.state = trac_pkg::TRAC_IDLE;
            end
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            r_reg.state <= trac_pkg::TRAC_IDLE;
            r_reg.ctrl <= 8'h00;
            r_reg.wdata <= 16'h0000;
            r_reg.status <= 8'h00;
            r_reg.in_word <= 16'h0000;
            r_reg.ack <= 1'b0;
            r_reg.unlocked <= 1'b0;
            r_reg.code <= trac_pkg::WRITE_UNLOCK_CODE_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flip-flops, high byte first
    assign STATUS_BYTE = r_reg.status;
    assign TERMINAL_IN_HI = r_reg.in_word[15:8];
    assign TERMINAL_IN_LO = r_reg.in_word[7:0];
    assign ANSWER_VALID = r_reg.ack;
    assign WRITE_UNLOCKED = r_reg.unlocked;
endmodule
`default_nettype wire

// ### test/trac_chk.sv
`default_nettype none
module trac_chk (
    input wire logic MCLK, RSTN, PD_STROBE, ANSWER_VALID, WRITE_UNLOCKED, // control
    input wire logic [7:0] CTRL_BYTE, HOST_OUT_HI, HOST_OUT_LO, MEAS_STATUS, // request
    input wire logic [7:0] STATUS_BYTE, TERMINAL_IN_HI, TERMINAL_IN_LO, // answer
    input wire logic [15:0] MEAS_WORD // normal value
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    logic s, w31;
    logic [1:0] k;
    logic [15:0] tin, hw;
    // request decode and joined words
    assign s = PD_STROBE;
    assign k = CTRL_BYTE[7:6];
    assign w31 = s && CTRL_BYTE == 8'hDF;
    assign tin = {TERMINAL_IN_HI, TERMINAL_IN_LO};
    assign hw = {HOST_OUT_HI, HOST_OUT_LO};
    property p_rd; s && k == 2'b10 |-> ##3 ANSWER_VALID && STATUS_BYTE == $past(CTRL_BYTE, 3);
    endproperty
    a_rd: assert property (p_rd) else $error("read echo wrong");
    property p_wr; s && k == 2'b11 |-> ##3 ANSWER_VALID && tin == 16'h0000
        && STATUS_BYTE == ($past(CTRL_BYTE, 3) & 8'hBF); endproperty
    a_wr: assert property (p_wr) else $error("write receipt wrong");
    property p_nm; s && !k[1] |=> ANSWER_VALID && STATUS_BYTE == $past(MEAS_STATUS)
        && tin == $past(MEAS_WORD); endproperty
    a_nm: assert property (p_nm) else $error("normal data wrong");
    property p_gap; s && k[1] |=> !ANSWER_VALID [*2]; endproperty
    a_gap: assert property (p_gap) else $error("early answer");
    property p_unl; w31 && hw == 16'h1235 |-> ##2 WRITE_UNLOCKED; endproperty
    a_unl: assert property (p_unl) else $error("unlock missed");
    property p_lck; w31 && hw != 16'h1235 |-> ##2 !WRITE_UNLOCKED; endproperty
    a_lck: assert property (p_lck) else $error("lock missed");
    // a reset edge clears the flag on its own, so only changes out of run are excused
    property p_keep; $past(RSTN) && $changed(WRITE_UNLOCKED) |-> $past(w31, 2); endproperty
    a_keep: assert property (p_keep) else $error("stray lock change");
    property p_hold; $past(RSTN) && !ANSWER_VALID |-> $stable(STATUS_BYTE) && $stable(tin);
    endproperty
    a_hold: assert property (p_hold) else $error("answer moved");
endmodule
bind trac_channel trac_chk u_chk (.*);
`default_nettype wire

// ### test/trac_host.sv
`default_nettype none
module trac_host (
    input wire logic clk, // process-data clock
    input wire logic ans, // answer pulse
    output logic stb, // request strobe
    output logic [7:0] ctl, // control byte
    output logic [15:0] w // output word
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {stb, ctl, w} = '0;
    // one exchange, next after the answer or at most 8 further cycles; released lines flip
    // the input word after a write is never used by this host
    task automatic xfer(input logic [7:0] c, input logic [15:0] d);
        int n;
        @(posedge clk);
        stb <= 1'b1;
        ctl <= c;
        w <= d;
        @(posedge clk);
        stb <= 1'b0;
        ctl <= ~c;
        w <= ~d;
        #1;
        for (n = 0; n < 8 && !ans; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// ### test/trac_channel_tb_top.sv
`default_nettype none
module trac_channel_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] c; logic [15:0] d; logic [7:0] s; logic [15:0] r;} trac_row_t;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] ms = 8'h00;
    logic [15:0] mw = 16'h0000;
    wire stb, av, unl;
    wire [7:0] ctl, st, thi, tlo;
    wire [15:0] w;
    int miscompares = 0;
    int n_compared = 0;
    trac_row_t rows [12] = '{'{8'h9F, 16'h5555, 8'h9F, 16'h0000},
        '{8'hDF, 16'h1235, 8'h9F, 16'h0000}, '{8'h9F, 16'h0000, 8'h9F, 16'h1235},
        '{8'hE0, 16'h0002, 8'hA0, 16'h0000}, '{8'hFF, 16'hBEEF, 8'hBF, 16'h0000},
        '{8'hC0, 16'h0001, 8'h80, 16'h0000}, '{8'hDF, 16'h0000, 8'h9F, 16'h0000},
        '{8'hE0, 16'h0005, 8'hA0, 16'h0000}, '{8'hA0, 16'h0000, 8'hA0, 16'h0002},
        '{8'hBF, 16'h0000, 8'hBF, 16'hBEEF}, '{8'h80, 16'h0000, 8'h80, 16'h0001},
        '{8'h3C, 16'h0000, 8'h5A, 16'hC3E1}};
    trac_channel u_dut (.MCLK(mclk), .RSTN(rstn), .PD_STROBE(stb), .CTRL_BYTE(ctl),
        .HOST_OUT_HI(w[15:8]), .HOST_OUT_LO(w[7:0]), .MEAS_STATUS(ms), .MEAS_WORD(mw),
        .STATUS_BYTE(st), .TERMINAL_IN_HI(thi), .TERMINAL_IN_LO(tlo), .ANSWER_VALID(av),
        .WRITE_UNLOCKED(unl));
    trac_host u_host (.clk(mclk), .ans(av), .stb(stb), .ctl(ctl), .w(w));
    always #50 mclk = ~mclk;
    // compare and count
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // table sweep, then reset while unlocked
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            {ms, mw} <= rows[i].c[7] ? ~{rows[i].s, rows[i].r} : {rows[i].s, rows[i].r};
            u_host.xfer(rows[i].c, rows[i].d);
            chk({av, st, thi, tlo}, {1'b1, rows[i].s, rows[i].r});
        end
        u_host.xfer(8'hDF, 16'h1235);
        rstn <= 1'b0;
        @(posedge mclk);
        #1;
        chk({unl, st, thi, tlo}, 25'h0);
        rstn <= 1'b1;
        u_host.xfer(8'h9F, 16'hFFFF);
        chk({av, st, thi, tlo}, {1'b1, 8'h9F, 16'h0000});
        give_verdict();
    end
    // hang guard
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
